// File: core/can_ts_pkg.sv
// constants, register map and carrier types of the mailbox overwrite
// and time-stamp block; shared by the top module and its two leaves
package can_ts_pkg;

  localparam int          MBOX_COUNT    = 32;
  localparam int          SYNC_MBOX     = 16;       // mailbox used for time sync
  localparam logic [31:0] ZERO_WORD     = 32'h00000000;
  localparam logic [3:0]  FULL_BE       = 4'hF;

  // register byte offsets
  localparam logic [7:0]  OFS_PROTECT   = 8'h00;
  localparam logic [7:0]  OFS_TX_PIN    = 8'h04;
  localparam logic [7:0]  OFS_RX_PIN    = 8'h08;
  localparam logic [7:0]  OFS_COUNTER   = 8'h0C;
  localparam logic [7:0]  OFS_MASTER    = 8'h10;
  localparam logic [7:0]  OFS_GFLAGS    = 8'h14;
  localparam logic [7:0]  OFS_GMASK     = 8'h18;
  localparam logic [7:0]  OFS_RX_PEND   = 8'h1C;
  localparam logic [7:0]  OFS_RX_LOST   = 8'h20;
  localparam logic [7:0]  OFS_STAMP_LO  = 8'h80;    // mailbox n stamp at 0x80 + 4n

  // field positions
  localparam int          PIN_FUNC_BIT  = 3;
  localparam int          MSB_CLR_BIT   = 14;
  localparam int          SYNC_CLR_BIT  = 15;
  localparam int          OVF_BIT       = 16;
  localparam int          IRQ_LINE_BIT  = 2;

  // reset values
  localparam logic [31:0] PROTECT_RST   = 32'h00000000;
  localparam logic        PIN_FUNC_RST  = 1'b0;
  localparam logic [31:0] COUNTER_RST   = 32'h00000000;

  // avalon-mm request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avm_req_t;

  // avalon-mm answer to the master
  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } avm_rsp_t;

endpackage

// File: core/stamp_counter.sv
// free-running 32-bit time-stamp counter
// assumes bit_tick is a one-cycle pulse per bit time on the same clock
`timescale 1ns/1ps
module stamp_counter (
  input  wire logic        clk,        // system clock
  input  wire logic        rst_b,      // async reset, active low
  input  wire logic        bit_tick,   // one pulse per bit time
  input  wire logic        hold,       // init, sleep or suspend
  input  wire logic        msb_clear,  // clear top bit only
  input  wire logic        sync_clear, // clear whole counter
  input  wire logic        load,       // software write
  input  wire logic [31:0] load_val,   // software write value
  output logic      [31:0] count,      // counter value
  output logic             msb_rise    // top bit went 0 to 1
);
  import can_ts_pkg::*;

  logic [31:0] next_count;

  // next value, priority load, sync clear, msb clear, tick
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_val;
    end else if (sync_clear) begin
      next_count = ZERO_WORD;
    end else begin
      if (msb_clear) begin
        next_count[31] = 1'b0;
      end
      if (bit_tick && !hold) begin
        next_count = next_count + 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= COUNTER_RST;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msb_rise <= 1'b0;
    end else begin
      msb_rise <= next_count[31] && !count[31];
    end
  end

endmodule // stamp_counter

// File: core/rx_store_select.sv
// picks the mailbox that takes an accepted receive message
// assumes match holds every mailbox whose identifier fits the message
`timescale 1ns/1ps
module rx_store_select (
  input  wire logic [31:0] match,      // matching mailboxes
  input  wire logic [31:0] pending,    // unread message held
  input  wire logic [31:0] protect,    // overwrite protection bits
  output logic             found,      // a mailbox takes it
  output logic       [4:0] index,      // chosen mailbox
  output logic             lost        // unread message replaced
);
  import can_ts_pkg::*;

  // ascending search; first free or unprotected match wins
  always_comb begin
    found = 1'b0;
    index = 5'h00;
    lost  = 1'b0;
    for (int i = 0; i < MBOX_COUNT; i++) begin
      if (!found && match[i]) begin
        if (!pending[i]) begin
          found = 1'b1;
          index = 5'(i);
        end else if (!protect[i]) begin
          found = 1'b1;
          index = 5'(i);
          lost  = 1'b1;
        end
      end
    end
  end

endmodule // rx_store_select

// File: core/can_mailbox_ts.sv
// mailbox overwrite decision, pin function control and time stamps
// assumes protocol engine, bit timing and message ram on clk; avalon slave
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module can_mailbox_ts (
  input  wire logic                clk,             // system clock 200 MHz
  input  wire logic                rst_b,           // async reset, active low
  input  wire can_ts_pkg::avm_req_t bus_req,        // avalon request
  output can_ts_pkg::avm_rsp_t     bus_rsp,         // avalon answer
  input  wire logic                bus_receive_pin, // receive pin, async
  output logic                     bus_transmit_pin,// transmit pin
  input  wire logic                tx_bit,          // bit from protocol engine
  output logic                     rx_bit,          // bit to protocol engine
  input  wire logic                bit_tick,        // pulse once per bit time
  input  wire logic                proto_busy,      // protocol owns registers
  input  wire logic                init_mode,       // initialization mode
  input  wire logic                sleep_mode,      // sleep mode
  input  wire logic                suspend_mode,    // suspend mode
  input  wire logic                protected_write_mode, // protected writes on
  input  wire logic                standard_compat_mode, // compatibility mode
  input  wire logic [31:0]         mbox_direction,  // 1 receive, 0 transmit
  input  wire logic                rx_accept,       // accepted message pulse
  input  wire logic [31:0]         rx_match,        // matching mailboxes
  input  wire logic                tx_done,         // transmit complete pulse
  input  wire logic [4:0]          tx_index,        // mailbox that sent
  output logic                     store_valid,     // store message pulse
  output logic [4:0]               store_index,     // mailbox to store into
  output logic [31:0]              rx_pending,      // unread message flags
  output logic [31:0]              rx_lost,         // lost message flags
  output logic                     irq_line_zero,   // global interrupt line 0
  output logic                     irq_line_one     // global interrupt line 1
);
  import can_ts_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // registers and wires

  logic [31:0] overwrite_protect;
  logic        tx_pin_func;
  logic        rx_pin_func;
  logic        mbox_sync_clear;
  logic        stamp_overflow_flag;
  logic        stamp_overflow_mask;
  logic        global_irq_line;
  logic [31:0] mbox_stamp [MBOX_COUNT];
  logic        bus_ack;
  logic [31:0] readdata;
  logic [31:0] next_readdata;
  logic        rx_meta;
  logic        rx_sync;
  logic        sel_found;
  logic [4:0]  sel_index;
  logic        sel_lost;
  logic        rx_ev;
  logic        rx_hold_v;
  logic        tx_hold_v;
  logic [4:0]  rx_hold_idx;
  logic [4:0]  tx_hold_idx;
  logic [31:0] rx_hold_val;
  logic [31:0] tx_hold_val;
  logic        commit_rx;
  logic        commit_tx;
  logic [31:0] count;
  logic        msb_rise;
  logic        wr_go;
  logic        full_word;
  logic        cnt_load;
  logic        cnt_sync;
  logic        cnt_msb_clr;

  // true when the request addresses the given offset
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the answer

  // acknowledge on second cycle of each request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (bus_req.read || bus_req.write) && !bus_ack;
    end
  end

  assign bus_rsp.waitrequest = (bus_req.read || bus_req.write) && !bus_ack;
  assign bus_rsp.readdata    = readdata;
  assign wr_go               = bus_req.write && bus_ack;
  assign full_word           = bus_req.byteenable == FULL_BE;

  // read multiplexer, unmapped and reserved read as zero
  always_comb begin
    next_readdata = ZERO_WORD;
    if (bus_req.address >= OFS_STAMP_LO) begin
      next_readdata = mbox_stamp[bus_req.address[6:2]];
    end else if (hit(bus_req.address, OFS_PROTECT)) begin
      next_readdata = overwrite_protect;
    end else if (hit(bus_req.address, OFS_TX_PIN)) begin
      next_readdata[PIN_FUNC_BIT] = tx_pin_func;
    end else if (hit(bus_req.address, OFS_RX_PIN)) begin
      next_readdata[PIN_FUNC_BIT] = rx_pin_func;
    end else if (hit(bus_req.address, OFS_COUNTER)) begin
      if (!standard_compat_mode) begin
        next_readdata = count;
      end
    end else if (hit(bus_req.address, OFS_MASTER)) begin
      next_readdata[SYNC_CLR_BIT] = mbox_sync_clear;
    end else if (hit(bus_req.address, OFS_GFLAGS)) begin
      next_readdata[OVF_BIT] = stamp_overflow_flag;
    end else if (hit(bus_req.address, OFS_GMASK)) begin
      next_readdata[OVF_BIT]      = stamp_overflow_mask;
      next_readdata[IRQ_LINE_BIT] = global_irq_line;
    end else if (hit(bus_req.address, OFS_RX_PEND)) begin
      next_readdata = rx_pending;
    end else if (hit(bus_req.address, OFS_RX_LOST)) begin
      next_readdata = rx_lost;
    end
  end

  // read data captured in the wait cycle, stands at the answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= ZERO_WORD;
    end else if (bus_req.read && !bus_ack) begin
      readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software controlled registers

  // one bit per mailbox, reset unprotected
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overwrite_protect <= PROTECT_RST;
    end else if (wr_go && full_word && hit(bus_req.address, OFS_PROTECT)) begin
      overwrite_protect <= bus_req.writedata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_pin_func <= PIN_FUNC_RST;
      rx_pin_func <= PIN_FUNC_RST;
    end else if (wr_go && full_word && protected_write_mode) begin
      if (hit(bus_req.address, OFS_TX_PIN)) begin
        tx_pin_func <= bus_req.writedata[PIN_FUNC_BIT];
      end
      if (hit(bus_req.address, OFS_RX_PIN)) begin
        rx_pin_func <= bus_req.writedata[PIN_FUNC_BIT];
      end
    end
  end

  // stored sync-clear enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mbox_sync_clear <= 1'b0;
    end else if (wr_go && full_word && hit(bus_req.address, OFS_MASTER)) begin
      mbox_sync_clear <= bus_req.writedata[SYNC_CLR_BIT];
    end
  end

  // global mask and line select, protected writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stamp_overflow_mask <= 1'b0;
      global_irq_line     <= 1'b0;
    end else if (wr_go && full_word && protected_write_mode &&
                 hit(bus_req.address, OFS_GMASK)) begin
      stamp_overflow_mask <= bus_req.writedata[OVF_BIT];
      global_irq_line     <= bus_req.writedata[IRQ_LINE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins

  // receive pin synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= bus_receive_pin;
      rx_sync <= rx_meta;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_transmit_pin <= 1'b1;
    end else begin
      bus_transmit_pin <= tx_pin_func ? tx_bit : 1'b1;
    end
  end

  assign rx_bit = rx_pin_func ? rx_sync : 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // receive store decision

  rx_store_select u_select (
    .match   (rx_match),
    .pending (rx_pending),
    .protect (overwrite_protect),
    .found   (sel_found),
    .index   (sel_index),
    .lost    (sel_lost)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      store_valid <= 1'b0;
      store_index <= 5'h00;
    end else begin
      store_valid <= rx_accept && sel_found;
      if (rx_accept && sel_found) begin
        store_index <= sel_index;
      end
    end
  end

  assign rx_ev = rx_accept && sel_found;

  // pending and lost flags, set wins over write-one clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_pending <= ZERO_WORD;
      rx_lost    <= ZERO_WORD;
    end else begin
      for (int i = 0; i < MBOX_COUNT; i++) begin
        if (rx_ev && sel_index == 5'(i)) begin
          rx_pending[i] <= 1'b1;
        end else if (wr_go && full_word && hit(bus_req.address, OFS_RX_PEND) &&
                     bus_req.writedata[i]) begin
          rx_pending[i] <= 1'b0;
        end
        if (rx_ev && sel_lost && sel_index == 5'(i)) begin
          rx_lost[i] <= 1'b1;
        end else if (wr_go && full_word && hit(bus_req.address, OFS_RX_LOST) &&
                     bus_req.writedata[i]) begin
          rx_lost[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // time-stamp counter

  // protected software load, not in compatibility mode
  assign cnt_load    = wr_go && full_word && protected_write_mode &&
                       !standard_compat_mode && hit(bus_req.address, OFS_COUNTER);
  assign cnt_msb_clr = wr_go && full_word && hit(bus_req.address, OFS_MASTER) &&
                       bus_req.writedata[MSB_CLR_BIT];
  // sync mailbox completion by its direction
  assign cnt_sync    = mbox_sync_clear &&
                       ((rx_ev && sel_index == 5'(SYNC_MBOX) && mbox_direction[SYNC_MBOX]) ||
                        (tx_done && tx_index == 5'(SYNC_MBOX) && !mbox_direction[SYNC_MBOX]));

  stamp_counter u_counter (
    .clk        (clk),
    .rst_b      (rst_b),
    .bit_tick   (bit_tick),
    .hold       (init_mode || sleep_mode || suspend_mode),
    .msb_clear  (cnt_msb_clr),
    .sync_clear (cnt_sync),
    .load       (cnt_load),
    .load_val   (bus_req.writedata),
    .count      (count),
    .msb_rise   (msb_rise)
  );

  // overflow flag, set wins over write-one clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stamp_overflow_flag <= 1'b0;
    end else if (msb_rise) begin
      stamp_overflow_flag <= 1'b1;
    end else if (wr_go && full_word && hit(bus_req.address, OFS_GFLAGS) &&
                 bus_req.writedata[OVF_BIT]) begin
      stamp_overflow_flag <= 1'b0;
    end
  end

  // masked request routed to one line
  assign irq_line_one  = stamp_overflow_flag && stamp_overflow_mask && global_irq_line;
  assign irq_line_zero = stamp_overflow_flag && stamp_overflow_mask && !global_irq_line;

  ////////////////////////////////////////////////////////////////////////
  // stamp capture; writes yield to the protocol engine

  // commit when idle, tx only once rx holds nothing, or forced by a newer event
  assign commit_rx = rx_hold_v && (!proto_busy || rx_ev);
  assign commit_tx = tx_hold_v && ((!proto_busy && !rx_hold_v) || tx_done);

  // counter value taken at the completion
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_hold_v <= 1'b0;
      tx_hold_v <= 1'b0;
    end else begin
      rx_hold_v <= rx_ev || (rx_hold_v && !commit_rx);
      tx_hold_v <= tx_done || (tx_hold_v && !commit_tx);
    end
  end

  // capture slots, data only
  always_ff @(posedge clk) begin
    if (rx_ev) begin
      rx_hold_idx <= sel_index;
      rx_hold_val <= count;
    end
    if (tx_done) begin
      tx_hold_idx <= tx_index;
      tx_hold_val <= count;
    end
  end

  // per-mailbox stamp, capture wins over software
  always_ff @(posedge clk) begin
    for (int i = 0; i < MBOX_COUNT; i++) begin
      if (commit_tx && tx_hold_idx == 5'(i)) begin
        mbox_stamp[i] <= tx_hold_val;
      end else if (commit_rx && rx_hold_idx == 5'(i)) begin
        mbox_stamp[i] <= rx_hold_val;
      end else if (wr_go && full_word && bus_req.address >= OFS_STAMP_LO &&
                   bus_req.address[6:2] == 5'(i)) begin
        mbox_stamp[i] <= bus_req.writedata;
      end
    end
  end

endmodule // can_mailbox_ts

// File: bench/can_mailbox_ts_properties.sv
// port checks of the mailbox overwrite and stamp block
// assumes one clock domain; bound into can_mailbox_ts
`timescale 1ns/1ps
module can_mailbox_ts_chk (
  input wire logic                 clk,              // clock
  input wire logic                 rst_b,            // reset, low
  input wire can_ts_pkg::avm_req_t bus_req,          // request
  input wire can_ts_pkg::avm_rsp_t bus_rsp,          // answer
  input wire logic                 bus_receive_pin,  // rx pin
  input wire logic                 bus_transmit_pin, // tx pin
  input wire logic                 tx_bit,           // engine out
  input wire logic                 rx_bit,           // engine in
  input wire logic                 rx_accept,        // accept
  input wire logic [31:0]          rx_match,         // matches
  input wire logic                 store_valid,      // store pulse
  input wire logic [4:0]           store_index,      // mailbox
  input wire logic [31:0]          rx_pending,       // unread
  input wire logic [31:0]          rx_lost,          // lost
  input wire logic                 irq_line_zero,    // line 0
  input wire logic                 irq_line_one      // line 1
);
  import can_ts_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  // bus answers after one wait cycle
  chk_bus_wait_once: assert property ((bus_req.read || bus_req.write) && bus_rsp.waitrequest |=>
    !bus_rsp.waitrequest) else $error("wait longer than one cycle");
  // transmit pin carries only the engine bit, rx bit only the receive pin, else recessive
  chk_tx_pin_source: assert property (!bus_transmit_pin |-> !$past(tx_bit))
    else $error("transmit pin low without engine bit");
  chk_rx_pin_source: assert property (!rx_bit |-> !$past(bus_receive_pin, 2))
    else $error("rx bit low without pin low");
  // receive decision
  chk_drop_no_match: assert property (rx_accept && rx_match == 32'h0 |=> !store_valid)
    else $error("store without match");
  chk_free_box_taken: assert property (rx_accept && (rx_match & ~rx_pending) != 32'h0 |=> store_valid)
    else $error("free matching mailbox not used");
  chk_store_fits_id: assert property (store_valid |-> (($past(rx_match) >> store_index) & 32'h1) != 32'h0)
    else $error("stored into non matching mailbox");
  chk_store_sets_pend: assert property (store_valid |-> rx_pending[store_index])
    else $error("pending not set on store");
  chk_lost_on_over: assert property (store_valid && (($past(rx_pending) >> store_index) & 32'h1) != 32'h0
    |-> rx_lost[store_index]) else $error("overwrite without lost flag");
  // one global line at a time
  chk_irq_one_line: assert property (!(irq_line_zero && irq_line_one))
    else $error("both interrupt lines high");
endmodule // can_mailbox_ts_chk
////////////////////////////////////////////////////////////////
bind can_mailbox_ts can_mailbox_ts_chk u_can_mailbox_ts_chk (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
  .bus_rsp(bus_rsp), .bus_receive_pin(bus_receive_pin), .bus_transmit_pin(bus_transmit_pin), .tx_bit(tx_bit),
  .rx_bit(rx_bit), .rx_accept(rx_accept), .rx_match(rx_match), .store_valid(store_valid),
  .store_index(store_index), .rx_pending(rx_pending), .rx_lost(rx_lost), .irq_line_zero(irq_line_zero),
  .irq_line_one(irq_line_one));

// File: bench/can_xcvr_model.sv
// bus transceiver: wired bus level with own transmit looped back
// assumes recessive-high bus; other nodes lumped in one input
`timescale 1ns/1ps
module can_xcvr_model (
  input  wire logic txd,       // controller transmit pin
  input  wire logic other_dom, // another node dominant
  output logic      rxd        // bus level to receive pin
);
  assign rxd = txd & ~other_dom;
endmodule // can_xcvr_model

// File: bench/tb_can_mailbox_ts.sv
// self-checking bench of the mailbox overwrite and stamp block
// assumes the avalon slave answers with one wait cycle
`timescale 1ns/1ps
module tb_can_mailbox_ts;
  import can_ts_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, tx_bit = 1'b1, bit_tick = 1'b0, busy = 1'b0;
  logic        pwm = 1'b0, compat = 1'b0, rx_accept = 1'b0, tx_done = 1'b0, other_dom = 1'b0;
  logic [2:0]  modes = 3'h0;
  logic [31:0] rx_match = 32'h0, mbox_dir = 32'h0, q;
  logic [4:0]  tx_index = 5'h0, store_index;
  avm_req_t    bus_req = '0;
  avm_rsp_t    bus_rsp;
  logic        pin_rx, pin_tx, rx_bit, store_valid, irq0, irq1;
  logic [31:0] rx_pending, rx_lost;
  int          bad_count = 0, cmp_count = 0, cyc = 0;
  // clock and design
  always #2.5 clk = ~clk;
  can_mailbox_ts u_can_mailbox_ts (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .bus_receive_pin(pin_rx), .bus_transmit_pin(pin_tx), .tx_bit(tx_bit), .rx_bit(rx_bit), .bit_tick(bit_tick),
    .proto_busy(busy), .init_mode(modes[0]), .sleep_mode(modes[1]), .suspend_mode(modes[2]),
    .protected_write_mode(pwm), .standard_compat_mode(compat), .mbox_direction(mbox_dir),
    .rx_accept(rx_accept), .rx_match(rx_match), .tx_done(tx_done), .tx_index(tx_index),
    .store_valid(store_valid), .store_index(store_index), .rx_pending(rx_pending), .rx_lost(rx_lost),
    .irq_line_zero(irq0), .irq_line_one(irq1));
  can_xcvr_model u_can_xcvr_model (.txd(pin_tx), .other_dom(other_dom), .rxd(pin_rx));
  ////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // one avalon cycle, held until waitrequest is sampled low
  task automatic bus_op(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    bus_req <= '{read: !w, write: w, address: a, writedata: d, byteenable: be};
    do @(posedge clk); while (bus_rsp.waitrequest !== 1'b0);
    q = bus_rsp.readdata;
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_op(1'b1, a, d, FULL_BE);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus_op(1'b0, a, 32'h0, FULL_BE);
    check(n, q, e);
  endtask
  task automatic tick;
    @(posedge clk) bit_tick <= 1'b1;
    @(posedge clk) bit_tick <= 1'b0;
  endtask
  task automatic tx_pulse(input logic [4:0] i);
    @(posedge clk) {tx_done, tx_index} <= {1'b1, i};
    @(posedge clk) tx_done <= 1'b0;
  endtask
  task automatic rx_msg(input logic [31:0] m, input logic v, input logic [4:0] i);
    @(posedge clk) {rx_accept, rx_match} <= {1'b1, m};
    @(posedge clk) rx_accept <= 1'b0;
    @(posedge clk);
    check("store_valid", 32'(store_valid), 32'(v));
    if (v) check("store_index", 32'(store_index), 32'(i));
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_pins;
    rd_chk("protect", OFS_PROTECT, 32'h0);
    rd_chk("counter", OFS_COUNTER, 32'h0);
    {tx_bit, other_dom} <= 2'b01;
    wr(OFS_TX_PIN, 32'hFFFFFFFF);
    rd_chk("tx_ctrl", OFS_TX_PIN, 32'h0);
    check("tx_pin", 32'(pin_tx), 32'h1);
    check("rx_bit", 32'(rx_bit), 32'h1);
    pwm <= 1'b1;
    wr(OFS_TX_PIN, 32'hFFFFFFFF);
    wr(OFS_RX_PIN, 32'hFFFFFFFF);
    rd_chk("tx_ctrl", OFS_TX_PIN, 32'h8);
    rd_chk("rx_ctrl", OFS_RX_PIN, 32'h8);
    check("tx_pin", 32'(pin_tx), 32'h0);
    {tx_bit, other_dom} <= 2'b10;
    repeat (4) @(posedge clk);
    check("rx_bit", 32'(rx_bit), 32'h1);
    other_dom <= 1'b1;
    repeat (4) @(posedge clk);
    check("rx_bit", 32'(rx_bit), 32'h0);
    other_dom <= 1'b0;
  endtask
  task automatic t_overwrite;
    wr(OFS_PROTECT, 32'h1);
    bus_op(1'b1, OFS_PROTECT, 32'hFFFFFFFF, 4'h3);
    rd_chk("protect", OFS_PROTECT, 32'h1);
    rx_msg(32'h3, 1'b1, 5'd0);
    rx_msg(32'h3, 1'b1, 5'd1);
    rx_msg(32'h1, 1'b0, 5'd0);
    check("rx_lost", rx_lost, 32'h0);
    wr(OFS_PROTECT, 32'h0);
    rx_msg(32'h1, 1'b1, 5'd0);
    check("rx_lost", rx_lost, 32'h1);
    check("rx_pending", rx_pending, 32'h3);
    wr(OFS_RX_PEND, 32'hFFFFFFFF);
    wr(OFS_RX_LOST, 32'hFFFFFFFF);
  endtask
  task automatic t_counter;
    pwm <= 1'b0;
    wr(OFS_COUNTER, 32'h55);
    rd_chk("counter", OFS_COUNTER, 32'h0);
    pwm <= 1'b1;
    wr(OFS_COUNTER, 32'h7FFFFFFF);
    tick;
    rd_chk("counter", OFS_COUNTER, 32'h80000000);
    rd_chk("flags", OFS_GFLAGS, 32'h00010000);
    tick;
    wr(OFS_MASTER, 32'h4000);
    rd_chk("counter", OFS_COUNTER, 32'h1);
    for (int i = 0; i < 3; i++) begin
      modes <= 3'(1 << i);
      tick;
      rd_chk("held", OFS_COUNTER, 32'h1);
    end
    modes <= 3'h0;
    tick;
    compat <= 1'b1;
    wr(OFS_COUNTER, 32'h99);
    rd_chk("compat", OFS_COUNTER, 32'h0);
    compat <= 1'b0;
    rd_chk("counter", OFS_COUNTER, 32'h2);
    wr(OFS_COUNTER, 32'hFFFFFFFF);
    tick;
    rd_chk("wrap", OFS_COUNTER, 32'h0);
  endtask
  task automatic t_stamps;
    wr(OFS_COUNTER, 32'h5);
    wr(OFS_STAMP_LO + 8'h08, 32'hA);
    busy <= 1'b1;
    tx_pulse(5'd2);
    repeat (3) @(posedge clk);
    rd_chk("stamp2", OFS_STAMP_LO + 8'h08, 32'hA);
    busy <= 1'b0;
    rd_chk("stamp2", OFS_STAMP_LO + 8'h08, 32'h5);
    wr(OFS_COUNTER, 32'h9);
    rx_msg(32'h10, 1'b1, 5'd4);
    rd_chk("stamp4", OFS_STAMP_LO + 8'h10, 32'h9);
    rd_chk("stamp2", OFS_STAMP_LO + 8'h08, 32'h5);
    wr(OFS_MASTER, 32'h8000);
    mbox_dir <= 32'h00010000;
    rx_msg(32'h00010000, 1'b1, 5'd16);
    rd_chk("sync_rx", OFS_COUNTER, 32'h0);
    rd_chk("stamp16", OFS_STAMP_LO + 8'h40, 32'h9);
    wr(OFS_COUNTER, 32'h7);
    mbox_dir <= 32'h0;
    tx_pulse(5'd16);
    rd_chk("sync_tx", OFS_COUNTER, 32'h0);
    rd_chk("stamp16", OFS_STAMP_LO + 8'h40, 32'h7);
  endtask
  task automatic t_irq;
    wr(OFS_GMASK, 32'h00010000);
    @(posedge clk) check("irq", {30'h0, irq1, irq0}, 32'h1);
    wr(OFS_GMASK, 32'h00010004);
    @(posedge clk) check("irq", {30'h0, irq1, irq0}, 32'h2);
    wr(OFS_GMASK, 32'h4);
    @(posedge clk) check("irq", {30'h0, irq1, irq0}, 32'h0);
    wr(OFS_GMASK, 32'h00010004);
    wr(OFS_GFLAGS, 32'h00010000);
    @(posedge clk) check("irq", {30'h0, irq1, irq0}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog on the whole run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run;
    end
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_pins;
    t_overwrite;
    t_counter;
    t_stamps;
    t_irq;
    complete_run;
  end
endmodule // tb_can_mailbox_ts
